// ==== dv/seg_status_groups_tb_top.sv ====
/*
  self-checking bench of the status event register groups.
  assumes the design and its package compiled before it.
*/
`timescale 1ns/1ps
module seg_status_groups_tb_top;
  import seg_pkg::*;
  logic clock, rst_n, cmdValid, rspValid, pendingOp, errValid, rv;
  seg_cmd_t cmdCode;
  logic [15:0] cmdData, rspData, m, qm, e, qe, rdat;
  logic [4:0] src;
  logic signed [15:0] errNumber;
  logic calibrating, measuring, internalRef, esbSummary, osbSummary, qsbSummary;
  logic [14:0] quesCondIn;
  logic [2:0] c;
  int num_errors, comparisons, n, k;
  int errs [10] = '{-400, -499, -500, -300, -399, 2000, -200, -299, -100, 1999};

  seg_status_groups dut (
    .clock, .rst_n, .cmdValid, .cmdCode, .cmdData, .rspValid, .rspData,
    .pendingOp, .queueEmptyRead(src[0]), .queueDataLost(src[1]),
    .internalFail(src[2]), .execFail(src[3]), .cmdFail(src[4]),
    .errValid, .errNumber, .calibrating, .measuring, .internalRef,
    .quesCondIn, .esbSummary, .osbSummary, .qsbSummary
  ); // seg_status_groups

  function automatic logic [7:0] errBit(int v);
    if (v <= -400 && v >= -499) return 8'h04;
    if ((v <= -300 && v >= -399) || v >= 2000) return 8'h08;
    if (v <= -200 && v >= -299) return 8'h10;
    if (v <= -100 && v >= -199) return 8'h20;
    return 8'h00;
  endfunction

  function automatic logic [7:0] srcBit(int i);
    return (i < 2) ? 8'h04 : 8'h08 << (i - 2);
  endfunction

  function automatic logic [15:0] opCond(logic [2:0] v);
    return {6'h00, v[0], 4'h0, v[1], 3'h0, v[2]};
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int i = 1);
    repeat (i) @(posedge clock);
    #1;
  endtask

  task automatic cmd(seg_cmd_t cc, logic [15:0] d = 16'h0000);
    cmdValid = 1'b1;
    cmdCode = cc;
    cmdData = d;
    tick();
    cmdValid = 1'b0;
    cmdCode = SEG_CMD_NONE;
    rv = rspValid;
    rdat = rspData;
    tick();
  endtask

  task automatic rd(seg_cmd_t cc, string what, logic [15:0] exp);
    cmd(cc);
    check({what, " valid"}, {15'h0000, rv}, 16'h0001);
    check(what, rdat, exp);
  endtask

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    #500000;
    num_errors++;
    conclude();
  end

  initial begin
    {rst_n, cmdValid, pendingOp, errValid, calibrating, measuring, internalRef} = '0;
    cmdCode = SEG_CMD_NONE;
    cmdData = 16'h0000;
    src = 5'h00;
    errNumber = 16'sh0000;
    quesCondIn = 15'h0000;
    void'($urandom(32'h252b));
    tick(5);
    rst_n = 1'b1;
    rd(SEG_CMD_SE_RD, "esr pon", 16'h0080);
    rd(SEG_CMD_SE_RD, "esr", 16'h0000);
    rd(SEG_CMD_SEN_RD, "ese", 16'h0000);
    rd(SEG_CMD_OEN_RD, "oen", 16'h0000);
    rd(SEG_CMD_QEN_RD, "qen", 16'h0000);
    cmd(seg_cmd_t'(4'he));
    check("unknown", {15'h0000, rv}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      src[i] = 1'b1;
      tick();
      src[i] = 1'b0;
      tick(3);
      rd(SEG_CMD_SE_RD, "esr src", {8'h00, srcBit(i)});
    end
    src[2] = 1'b1;
    tick();
    src[2] = 1'b0;
    tick(3);
    cmd(SEG_CMD_CLS);
    rd(SEG_CMD_SE_RD, "esr cls", 16'h0000);
    for (int i = 0; i < 18; i++) begin
      if (i < 10) n = errs[i];
      else if (i % 2 == 1) n = -int'($urandom_range(100, 599));
      else n = 2000 + int'($urandom_range(0, 30000));
      errValid = 1'b1;
      errNumber = 16'(n);
      tick();
      errValid = 1'b0;
      tick(3);
      rd(SEG_CMD_SE_RD, "esr err", {8'h00, errBit(n)});
    end
    pendingOp = 1'b1;
    tick();
    cmd(SEG_CMD_OPC);
    tick(2);
    pendingOp = 1'b0;
    tick(4);
    rd(SEG_CMD_SE_RD, "esr opc", 16'h0001);
    pendingOp = 1'b1;
    tick(2);
    pendingOp = 1'b0;
    tick(4);
    rd(SEG_CMD_SE_RD, "esr no opc", 16'h0000);
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 16'hffff : 16'($urandom);
      k = $urandom_range(0, 4);
      cmd(SEG_CMD_SEN_WR, m);
      rd(SEG_CMD_SEN_RD, "ese", {8'h00, m[7:0] & 8'hbd});
      src[k] = 1'b1;
      tick();
      src[k] = 1'b0;
      tick(3);
      check("esb", {15'h0000, esbSummary}, {15'h0000, |(m[7:0] & srcBit(k))});
      rd(SEG_CMD_SE_RD, "esr", {8'h00, srcBit(k)});
      tick(2);
      check("esb clr", {15'h0000, esbSummary}, 16'h0000);
    end
    for (int i = 0; i < 10; i++) begin
      c = 3'($urandom);
      m = (i == 0) ? 16'hffff : 16'($urandom);
      qm = (i == 0) ? 16'hffff : 16'($urandom);
      quesCondIn = 15'($urandom);
      qe = {1'b0, quesCondIn};
      e = opCond(c);
      cmd(SEG_CMD_OEN_WR, m);
      cmd(SEG_CMD_QEN_WR, qm);
      rd(SEG_CMD_OEN_RD, "oen", m & 16'h0211);
      rd(SEG_CMD_QEN_RD, "qen", qm & 16'h7fff);
      {calibrating, measuring, internalRef} = c;
      tick(3);
      rd(SEG_CMD_OC_RD, "oc", e);
      rd(SEG_CMD_OC_RD, "oc again", e);
      rd(SEG_CMD_QC_RD, "qc", qe);
      check("osb", {15'h0000, osbSummary}, {15'h0000, |(e & m)});
      check("qsb", {15'h0000, qsbSummary}, {15'h0000, |(qe & qm)});
      {calibrating, measuring, internalRef} = 3'b000;
      quesCondIn = 15'h0000;
      tick(2);
      rd(SEG_CMD_OC_RD, "oc off", 16'h0000);
      if (i % 2 == 1) cmd(SEG_CMD_CLS);
      rd(SEG_CMD_OE_RD, "oe", (i % 2 == 1) ? 16'h0000 : e);
      rd(SEG_CMD_QE_RD, "qe", (i % 2 == 1) ? 16'h0000 : qe);
      rd(SEG_CMD_OE_RD, "oe clr", 16'h0000);
      rd(SEG_CMD_QE_RD, "qe clr", 16'h0000);
    end
    cmd(SEG_CMD_SEN_WR, 16'h00ff);
    cmd(SEG_CMD_OEN_WR, 16'hffff);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd(SEG_CMD_SEN_RD, "ese rst", 16'h0000);
    rd(SEG_CMD_OEN_RD, "oen rst", 16'h0000);
    rd(SEG_CMD_SE_RD, "esr rst", 16'h0080);
    conclude();
  end
endmodule // seg_status_groups_tb_top

// ==== verilog/seg_defs.svh ====
/*
  bit positions, masks, reset values and error-number bounds of the
  status event register groups; assumes inclusion by bare name.
*/
`ifndef SEG_DEFS_SVH
`define SEG_DEFS_SVH

// standard event status bits
`define SEG_SE_OPC 0
`define SEG_SE_QYE 2
`define SEG_SE_DDE 3
`define SEG_SE_EXE 4
`define SEG_SE_CME 5
`define SEG_SE_PON 7
`define SEG_SE_USED 8'hbd
`define SEG_SE_RESET 8'h80

// operation condition bits
`define SEG_OP_CAL 0
`define SEG_OP_MEAS 4
`define SEG_OP_IREF 9
`define SEG_OP_USED 16'h0211
`define SEG_QU_USED 16'h7fff
`define SEG_REG_RESET 16'h0000

// status byte summary bit positions
`define SEG_SB_QSB 3
`define SEG_SB_ESB 5
`define SEG_SB_OSB 7

// error number class bounds
`define SEG_QYE_LO -400
`define SEG_QYE_HI -499
`define SEG_DDE_LO -300
`define SEG_DDE_HI -399
`define SEG_DDE_POS 2000
`define SEG_EXE_LO -200
`define SEG_EXE_HI -299
`define SEG_CME_LO -100
`define SEG_CME_HI -199

`endif

// ==== verilog/seg_pkg.sv ====
/*
  types of the status event register groups: the command codes of the
  command port; assumes nothing of its surroundings.
*/
package seg_pkg;

  typedef enum logic [3:0] {
    SEG_CMD_NONE = 4'h0,
    SEG_CMD_CLS = 4'h1,
    SEG_CMD_OPC = 4'h2,
    SEG_CMD_SE_RD = 4'h3,
    SEG_CMD_SEN_WR = 4'h4,
    SEG_CMD_SEN_RD = 4'h5,
    SEG_CMD_OC_RD = 4'h6,
    SEG_CMD_OE_RD = 4'h7,
    SEG_CMD_OEN_WR = 4'h8,
    SEG_CMD_OEN_RD = 4'h9,
    SEG_CMD_QC_RD = 4'ha,
    SEG_CMD_QE_RD = 4'hb,
    SEG_CMD_QEN_WR = 4'hc,
    SEG_CMD_QEN_RD = 4'hd
  } seg_cmd_t;

endpackage

// ==== verilog/seg_status_groups.sv ====
/*
  standard event, operation and questionable status groups with
  summary bits for the status byte. assumes the command parser, the
  error queue and the status sources run on the same clock, and that
  rst_n is asserted at every power-on.
*/
`timescale 1ns/1ps
`include "seg_defs.svh"

// Operation
// - opc bit set on pending true-to-false once armed by an opc command
// - query error on empty read or loss
// - errors -400..-499 set query error
// - internal failures, -300..-399, >=2000 set bit 3
// - errors -200..-299 set execution error bit
// - syntax, unknown command, trigger set bit 5
// - power-on sets bit 7
// - bits 1 and 6 not implemented
// - event status read returns then clears
// - enable mask gates bits into summary
// - enable mask read/write, cleared by reset
// - condition registers live, read unchanged
// - event bits sticky until read
// - event read or clear-status clears
// - group enable gates group summary bit
// - group enables set by write, cleared by reset
// - calibrating bit0, measuring bit4, internal-ref bit9
// - bit 15 always reads zero
// - status byte bit 5 is event summary
// - status byte bit 7 summarises operation
// - status byte bit 3 summarises questionable
module seg_status_groups (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // command port
  input wire logic cmdValid,
  input wire seg_pkg::seg_cmd_t cmdCode,
  input wire logic [15:0] cmdData,
  output logic rspValid,
  output logic [15:0] rspData,
  // event sources
  input wire logic pendingOp,
  input wire logic queueEmptyRead,
  input wire logic queueDataLost,
  input wire logic internalFail,
  input wire logic execFail,
  input wire logic cmdFail,
  input wire logic errValid,
  input wire logic signed [15:0] errNumber,
  // condition sources
  input wire logic calibrating,
  input wire logic measuring,
  input wire logic internalRef,
  input wire logic [14:0] quesCondIn,
  // status byte summaries
  output logic esbSummary,
  output logic osbSummary,
  output logic qsbSummary
);
  import seg_pkg::*;

  logic [7:0] seStat_r, seStat_nxt;
  logic [7:0] seEn_r, seEn_nxt;
  logic [15:0] opCond_r, opCond_nxt;
  logic [15:0] opEvt_r, opEvt_nxt;
  logic [15:0] opEn_r, opEn_nxt;
  logic [15:0] quCond_r, quCond_nxt;
  logic [15:0] quEvt_r, quEvt_nxt;
  logic [15:0] quEn_r, quEn_nxt;
  logic opcArm_r, opcArm_nxt;
  logic pendPrev_r, pendPrev_nxt;
  logic rspValid_r, rspValid_nxt;
  logic [15:0] rspData_r, rspData_nxt;
  logic esb_r, esb_nxt;
  logic osb_r, osb_nxt;
  logic qsb_r, qsb_nxt;
  logic [7:0] seSet;
  logic [15:0] opLive;
  logic [15:0] quLive;
  logic isCls;

  // error number to event bit class
  function automatic logic [7:0] errClass(input logic signed [15:0] num);
    logic [7:0] m;
    m = 8'h00;
    if (num <= `SEG_QYE_LO && num >= `SEG_QYE_HI) begin
      m[`SEG_SE_QYE] = 1'b1;
    end
    if ((num <= `SEG_DDE_LO && num >= `SEG_DDE_HI) || num >= `SEG_DDE_POS) begin
      m[`SEG_SE_DDE] = 1'b1;
    end
    if (num <= `SEG_EXE_LO && num >= `SEG_EXE_HI) begin
      m[`SEG_SE_EXE] = 1'b1;
    end
    if (num <= `SEG_CME_LO && num >= `SEG_CME_HI) begin
      m[`SEG_SE_CME] = 1'b1;
    end
    return m;
  endfunction

  always_comb begin
    isCls = cmdValid && cmdCode == SEG_CMD_CLS;
    // live condition images
    opLive = 16'h0000;
    opLive[`SEG_OP_CAL] = calibrating;
    opLive[`SEG_OP_MEAS] = measuring;
    opLive[`SEG_OP_IREF] = internalRef;
    quLive = {1'b0, quesCondIn} & `SEG_QU_USED;
    opCond_nxt = opLive;
    quCond_nxt = quLive;
    pendPrev_nxt = pendingOp;
    // standard event sources
    seSet = 8'h00;
    seSet[`SEG_SE_OPC] = opcArm_r && pendPrev_r && !pendingOp;
    seSet[`SEG_SE_QYE] = queueEmptyRead || queueDataLost;
    seSet[`SEG_SE_DDE] = internalFail;
    seSet[`SEG_SE_EXE] = execFail;
    seSet[`SEG_SE_CME] = cmdFail;
    if (errValid) begin
      seSet = seSet | errClass(errNumber);
    end
    // opc arming
    opcArm_nxt = opcArm_r;
    if (seSet[`SEG_SE_OPC] || isCls) begin
      opcArm_nxt = 1'b0;
    end
    if (cmdValid && cmdCode == SEG_CMD_OPC) begin
      opcArm_nxt = 1'b1;
    end
    // sticky events, set wins over clear
    seStat_nxt = seStat_r;
    opEvt_nxt = opEvt_r;
    quEvt_nxt = quEvt_r;
    if (isCls) begin
      seStat_nxt = 8'h00;
      opEvt_nxt = 16'h0000;
      quEvt_nxt = 16'h0000;
    end
    if (cmdValid && cmdCode == SEG_CMD_SE_RD) begin
      seStat_nxt = 8'h00;
    end
    if (cmdValid && cmdCode == SEG_CMD_OE_RD) begin
      opEvt_nxt = 16'h0000;
    end
    if (cmdValid && cmdCode == SEG_CMD_QE_RD) begin
      quEvt_nxt = 16'h0000;
    end
    seStat_nxt = (seStat_nxt | seSet) & `SEG_SE_USED;
    opEvt_nxt = (opEvt_nxt | (opLive & ~opCond_r)) & `SEG_OP_USED;
    quEvt_nxt = (quEvt_nxt | (quLive & ~quCond_r)) & `SEG_QU_USED;
    // enable masks
    seEn_nxt = seEn_r;
    opEn_nxt = opEn_r;
    quEn_nxt = quEn_r;
    if (cmdValid && cmdCode == SEG_CMD_SEN_WR) begin
      seEn_nxt = cmdData[7:0] & `SEG_SE_USED;
    end
    if (cmdValid && cmdCode == SEG_CMD_OEN_WR) begin
      opEn_nxt = cmdData & `SEG_OP_USED;
    end
    if (cmdValid && cmdCode == SEG_CMD_QEN_WR) begin
      quEn_nxt = cmdData & `SEG_QU_USED;
    end
    // query answers
    rspValid_nxt = 1'b0;
    rspData_nxt = rspData_r;
    if (cmdValid) begin
      rspValid_nxt = 1'b1;
      unique case (cmdCode)
        SEG_CMD_SE_RD: rspData_nxt = {8'h00, seStat_r};
        SEG_CMD_SEN_RD: rspData_nxt = {8'h00, seEn_r};
        SEG_CMD_OC_RD: rspData_nxt = opCond_r;
        SEG_CMD_OE_RD: rspData_nxt = opEvt_r;
        SEG_CMD_OEN_RD: rspData_nxt = opEn_r;
        SEG_CMD_QC_RD: rspData_nxt = quCond_r;
        SEG_CMD_QE_RD: rspData_nxt = quEvt_r;
        SEG_CMD_QEN_RD: rspData_nxt = quEn_r;
        default: rspValid_nxt = 1'b0;
      endcase
    end
    // summaries
    esb_nxt = |(seStat_r & seEn_r);
    osb_nxt = |(opEvt_r & opEn_r);
    qsb_nxt = |(quEvt_r & quEn_r);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seStat_r <= `SEG_SE_RESET;
      seEn_r <= 8'h00;
      opCond_r <= `SEG_REG_RESET;
      opEvt_r <= `SEG_REG_RESET;
      opEn_r <= `SEG_REG_RESET;
      quCond_r <= `SEG_REG_RESET;
      quEvt_r <= `SEG_REG_RESET;
      quEn_r <= `SEG_REG_RESET;
      opcArm_r <= 1'b0;
      pendPrev_r <= 1'b0;
      rspValid_r <= 1'b0;
      rspData_r <= 16'h0000;
      esb_r <= 1'b0;
      osb_r <= 1'b0;
      qsb_r <= 1'b0;
    end else begin
      seStat_r <= seStat_nxt;
      seEn_r <= seEn_nxt;
      opCond_r <= opCond_nxt;
      opEvt_r <= opEvt_nxt;
      opEn_r <= opEn_nxt;
      quCond_r <= quCond_nxt;
      quEvt_r <= quEvt_nxt;
      quEn_r <= quEn_nxt;
      opcArm_r <= opcArm_nxt;
      pendPrev_r <= pendPrev_nxt;
      rspValid_r <= rspValid_nxt;
      rspData_r <= rspData_nxt;
      esb_r <= esb_nxt;
      osb_r <= osb_nxt;
      qsb_r <= qsb_nxt;
    end
  end

  assign rspValid = rspValid_r;
  assign rspData = rspData_r;
  assign esbSummary = esb_r;
  assign osbSummary = osb_r;
  assign qsbSummary = qsb_r;

  // checks
  opc_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
    opcArm_r && pendPrev_r && !pendingOp |=> seStat_r[`SEG_SE_OPC])
    else $error("opc not set on pending fall");
  qye_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    queueEmptyRead || queueDataLost |=> seStat_r[`SEG_SE_QYE])
    else $error("query error not set");
  err_class_a: assert property (@(posedge clock) disable iff (!rst_n)
    errValid && errNumber <= -16'sd400 && errNumber >= -16'sd499 && !internalFail &&
    !(cmdValid && (cmdCode == SEG_CMD_SE_RD || cmdCode == SEG_CMD_CLS))
    |=> seStat_r[`SEG_SE_QYE] && seStat_r[`SEG_SE_DDE] == $past(seStat_r[`SEG_SE_DDE]))
    else $error("query class error mismatch");
  dde_pos_a: assert property (@(posedge clock) disable iff (!rst_n)
    errValid && errNumber >= 16'sd2000 |=> seStat_r[`SEG_SE_DDE])
    else $error("positive error not device class");
  exe_cls_a: assert property (@(posedge clock) disable iff (!rst_n)
    errValid && errNumber == -16'sd200 |=> seStat_r[`SEG_SE_EXE])
    else $error("execution class not set");
  unused_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    !seStat_r[1] && !seStat_r[6] && !opEvt_r[15] && !opEn_r[15] && !quEvt_r[15])
    else $error("unused bit set");
  esr_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_SE_RD && seSet == 8'h00
    |=> rspValid && rspData == {8'h00, $past(seStat_r)} && seStat_r == 8'h00)
    else $error("event status read wrong");
  sticky_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(cmdValid && (cmdCode == SEG_CMD_SE_RD || cmdCode == SEG_CMD_CLS))
    |=> ($past(seStat_r) & ~seStat_r) == 8'h00)
    else $error("sticky bit lost");
  esb_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 esbSummary == |($past(seStat_r) & $past(seEn_r)))
    else $error("event summary wrong");
  op_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(measuring) |=> opEvt_r[`SEG_OP_MEAS] && opCond_r[`SEG_OP_MEAS])
    else $error("operation event not latched");
  cond_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 opCond_r[`SEG_OP_CAL] == $past(calibrating) &&
    opCond_r[`SEG_OP_IREF] == $past(internalRef))
    else $error("condition not live");
  osb_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 osbSummary == |($past(opEvt_r) & $past(opEn_r)))
    else $error("operation summary wrong");
  qsb_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 qsbSummary == |($past(quEvt_r) & $past(quEn_r)))
    else $error("questionable summary wrong");
  cls_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_CLS |=> opEvt_r == (opCond_r & ~$past(opCond_r)) &&
    quEvt_r == (quCond_r & ~$past(quCond_r)))
    else $error("clear status left events");
  oe_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_OE_RD |=> rspValid && rspData == $past(opEvt_r) &&
    opEvt_r == (opCond_r & ~$past(opCond_r)))
    else $error("operation event read wrong");
  qe_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_QE_RD |=> rspValid && rspData == $past(quEvt_r) &&
    quEvt_r == (quCond_r & ~$past(quCond_r)))
    else $error("questionable event read wrong");
  oen_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_OEN_WR |=> opEn_r == ($past(cmdData) & `SEG_OP_USED))
    else $error("operation enable write wrong");
  qen_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_QEN_WR |=> quEn_r == ($past(cmdData) & `SEG_QU_USED))
    else $error("questionable enable write wrong");
  sen_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdValid && cmdCode == SEG_CMD_SEN_WR |=> seEn_r == ($past(cmdData[7:0]) & `SEG_SE_USED))
    else $error("event enable write wrong");
  cond_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 opCond_r[`SEG_OP_MEAS] == $past(measuring) && (opCond_r & ~`SEG_OP_USED) == 16'h0000)
    else $error("operation condition map wrong");
  top_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    !opCond_r[15] && !quCond_r[15] && !quEn_r[15] && !rspData[15])
    else $error("top bit set");
  cme_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmdFail |=> seStat_r[`SEG_SE_CME])
    else $error("command error not set");
  exe_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    execFail |=> seStat_r[`SEG_SE_EXE])
    else $error("execution error not set");

endmodule // seg_status_groups
